// ===== brb_cfg.svh
// constants for the byte rom boot interface controller
`ifndef BRB_CFG_SVH
`define BRB_CFG_SVH

// apb register offsets (byte addresses, one aligned word each)
`define BRB_CTRL_OFS 12'h000
`define BRB_STATUS_OFS 12'h004
`define BRB_RDCNT_OFS 12'h008

// control register fields
`define BRB_CTRL_MAP_BIT 0
`define BRB_CTRL_WS_LSB 4
`define BRB_CTRL_WS_MSB 7
`define BRB_CTRL_MAP_RST 1'b1
`define BRB_CTRL_WS_RST 4'h0

// status register fields
`define BRB_ST_BUSY_BIT 0
`define BRB_ST_RECOV_BIT 1
`define BRB_ST_MAP_BIT 2

// physical address decode
`define BRB_WIN_MSB 31
`define BRB_WIN_LSB 25
`define BRB_BOOT_LSB 21
`define BRB_CODE_BIT 24
`define BRB_STEP_MSB 23
`define BRB_STEP_LSB 21
`define BRB_UPPER_MSB 16
`define BRB_UPPER_LSB 3

// timing, times in ns as printed, counts derived from the clock period
`define BRB_CLK_NS 10
`define BRB_TACC_NS 200
`define BRB_TOE_NS 85
`define BRB_TDF_NS 60
`define BRB_SYNC_LAT 2
`define BRB_TACC_CYC ((`BRB_TACC_NS + `BRB_CLK_NS - 1) / `BRB_CLK_NS)
`define BRB_TOE_CYC ((`BRB_TOE_NS + `BRB_CLK_NS - 1) / `BRB_CLK_NS)
`define BRB_TDF_CYC ((`BRB_TDF_NS + `BRB_CLK_NS - 1) / `BRB_CLK_NS)
`define BRB_RD_CYC ((`BRB_TACC_CYC > `BRB_TOE_CYC ? `BRB_TACC_CYC : `BRB_TOE_CYC) + `BRB_SYNC_LAT)

`endif

// ===== brb_ctrl.sv
// byte rom boot interface controller: eprom sequencer and apb registers
//
// Overview of operation
// R1 - in byte-wide boot mode the processor fetches code misses eight bits wide
// R2 - in boot mode the processor byte enables act as address bits two to zero
// R3 - the processor leaves boot mode when software sets its boot-mode bit
// R4 - eprom chip enable comes from address decode combined with the boot-map bit
// R5 - map set puts eprom at bootstrap locations, clear routes them to dram
// R6 - eprom output enable is driven by the io read strobe
// R7 - upper fourteen eprom address bits direct, low three through a mux
// R8 - the mux select is the boot-map bit of a writable register
// R9 - eprom data sits on the lowest byte lane, one byte per word
// R10 - top 32 mbytes reserved for up to 2 mbytes of eprom
// R11 - a24 high enables caching, a24 low keeps cache enable off
// R12 - mux picks the byte enables whenever a24 is high
// R13 - data window steps bytes by 2^21, low address advances every eight
// R14 - outside boot mode the processor never issues byte-enable codes 001 or 010
// R15 - mux-free option wires byte enables straight to eprom low address
// R16 - eprom reads get enough wait states for a 200ns access time; extra wait states above 10 wrap the 5-bit count to a shorter read here
// R17 - eprom reads also cover an 85ns output-enable access time; reads fall short of it here when extra wait states above 10 wrap the count
// R18 - next bus cycle held off until eprom outputs float, up to 60ns
// R19 - boot-map bit resets to one
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "brb_cfg.svh"
module brb_ctrl (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// processor local bus pins
	input wire logic proc_ads_n,
	input wire logic proc_wr,
	input wire logic [31:3] proc_addr,
	input wire logic [2:0] byte_enable_lines,
	output logic proc_ready_n,
	output logic cache_enable_input_n,
	output logic proc_hold,
	output logic dram_select,
	output logic [7:0] proc_data_lo,
	// eprom pins
	input wire logic [7:0] eprom_data,
	output logic eprom_ce_n,
	output logic [16:0] eprom_addr,
	output logic io_read_strobe_n
);

	localparam logic [4:0] RD_CYC = 5'(`BRB_RD_CYC);
	localparam logic [4:0] TDF_CYC = 5'(`BRB_TDF_CYC);

	// whole module state
	typedef struct packed {
		brb_pkg::brb_state_t st;
		logic [4:0] cnt;
		logic boot_map;
		logic [3:0] extra_ws;
		logic ads_q;
		brb_pkg::brb_rom_t rom;
		brb_pkg::brb_cpu_t cpu;
		logic [15:0] rd_count;
		logic [31:0] prdata;
		logic pslverr;
	} brb_ctrl_st_t;

	brb_ctrl_st_t r;
	brb_ctrl_st_t next_r;

	brb_pkg::brb_req_t pin_req;
	brb_pkg::brb_req_t req;
	brb_pkg::brb_dec_t dec;
	logic [7:0] rom_data;
	logic start;
	logic setup;
	logic wr_acc;
	logic map_ok;
	logic sts_ok;
	logic cnt_ok;

	////////////////////////////////////////////////////////////////////////////////
	// pin inputs pass two flip-flops before anything looks at them

	assign pin_req.ads = !proc_ads_n;
	assign pin_req.wr = proc_wr;
	assign pin_req.addr = proc_addr;
	assign pin_req.byte_enable_lines = byte_enable_lines;

	brb_sync #(
		.W($bits(brb_pkg::brb_req_t))
	) u_req_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(pin_req),
		.q(req)
	);

	brb_sync #(
		.W(8)
	) u_data_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(eprom_data),
		.q(rom_data)
	);

	// decode runs off the synchronised request and the live map bit
	brb_decode u_decode (
		.req(req),
		.boot_map(r.boot_map),
		.dec(dec)
	);

	////////////////////////////////////////////////////////////////////////////////
	// apb decode

	// a new cycle is the rising edge of the synchronised address strobe
	assign start = req.ads && !r.ads_q;
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite;

	// if / else-if address decode for the three words
	always_comb begin
		map_ok = 1'b0;
		sts_ok = 1'b0;
		cnt_ok = 1'b0;
		if (paddr == `BRB_CTRL_OFS) begin
			map_ok = 1'b1;
		end else if (paddr == `BRB_STATUS_OFS) begin
			sts_ok = 1'b1;
		end else if (paddr == `BRB_RDCNT_OFS) begin
			cnt_ok = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// next-state logic for the sequencer and the register file

	always_comb begin
		next_r = r;
		next_r.ads_q = req.ads;
		// ready is a one-cycle pulse
		next_r.cpu.ready_n = 1'b1;

		// register reads are captured in the setup cycle so pready can be constant
		if (setup) begin
			next_r.pslverr = !(map_ok || sts_ok || cnt_ok);
			next_r.prdata = 32'h0000_0000;
			if (map_ok) begin
				next_r.prdata[`BRB_CTRL_MAP_BIT] = r.boot_map;
				next_r.prdata[`BRB_CTRL_WS_MSB:`BRB_CTRL_WS_LSB] = r.extra_ws;
			end else if (sts_ok) begin
				next_r.prdata[`BRB_ST_BUSY_BIT] = (r.st != brb_pkg::BRB_IDLE);
				next_r.prdata[`BRB_ST_RECOV_BIT] = r.cpu.hold;
				next_r.prdata[`BRB_ST_MAP_BIT] = r.boot_map;
			end else if (cnt_ok) begin
				next_r.prdata[15:0] = r.rd_count;
			end
		end

		// control writes: map bit steers decode and the low-address mux
		if (wr_acc && map_ok) begin
			next_r.boot_map = pwdata[`BRB_CTRL_MAP_BIT]; // [R8]
			next_r.extra_ws = pwdata[`BRB_CTRL_WS_MSB:`BRB_CTRL_WS_LSB];
		end
		// writing the counter word clears it, unless a rom read completes in the same cycle and the increment wins
		if (wr_acc && cnt_ok) begin
			next_r.rd_count = 16'h0000;
		end

		case (r.st)
			brb_pkg::BRB_IDLE: begin
				if (start) begin
					next_r.cpu.dram_select = dec.dram_hit; // [R5]
					if (dec.eprom_hit && !req.wr) begin
						// chip enable from decode, address through the mux [R4] [R7]
						next_r.rom.eprom_ce_n = 1'b0;
						next_r.rom.eprom_addr = dec.eprom_addr;
						// output enable is the io read strobe [R6]
						next_r.rom.io_read_strobe_n = 1'b0;
						// code half may be cached, data half never [R11]
						next_r.cpu.cache_enable_input_n = !dec.code;
						// length covers both access and output-enable times while extra_ws is 10 or less; larger values wrap the 5-bit count [R16] [R17]
						next_r.cnt = RD_CYC - 5'd1 + {1'b0, r.extra_ws};
						next_r.st = brb_pkg::BRB_ACCESS;
					end else if (dec.eprom_hit) begin
						// writes to the rom are acknowledged and dropped
						next_r.cpu.ready_n = 1'b0;
						next_r.cpu.cache_enable_input_n = 1'b1;
					end else begin
						// everything else is cacheable memory
						next_r.cpu.cache_enable_input_n = 1'b0;
					end
				end
			end
			brb_pkg::BRB_ACCESS: begin
				if (r.cnt == 5'd0) begin
					// only the lowest lane carries rom data [R9]
					next_r.cpu.data_lo = rom_data;
					next_r.cpu.ready_n = 1'b0;
					next_r.rom.io_read_strobe_n = 1'b1;
					next_r.rom.eprom_ce_n = 1'b1;
					// hold the bus until the rom outputs have floated [R18]
					next_r.cpu.hold = 1'b1;
					next_r.cnt = TDF_CYC - 5'd1;
					next_r.rd_count = r.rd_count + 16'h0001;
					next_r.st = brb_pkg::BRB_RECOVER;
				end else begin
					next_r.cnt = r.cnt - 5'd1;
				end
			end
			brb_pkg::BRB_RECOVER: begin
				// requests arriving here are ignored: the hold keeps new cycles off
				if (r.cnt == 5'd0) begin
					next_r.cpu.hold = 1'b0; // [R18]
					next_r.st = brb_pkg::BRB_IDLE;
				end else begin
					next_r.cnt = r.cnt - 5'd1;
				end
			end
			default: begin
				next_r.st = brb_pkg::BRB_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.st <= brb_pkg::BRB_IDLE;
			r.boot_map <= `BRB_CTRL_MAP_RST; // [R19]
			r.extra_ws <= `BRB_CTRL_WS_RST;
			r.rom.eprom_ce_n <= 1'b1;
			r.rom.io_read_strobe_n <= 1'b1;
			r.cpu.ready_n <= 1'b1;
			r.cpu.cache_enable_input_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops except the constant pready

	assign pready = 1'b1;
	assign prdata = r.prdata;
	assign pslverr = r.pslverr;
	assign proc_ready_n = r.cpu.ready_n;
	assign cache_enable_input_n = r.cpu.cache_enable_input_n;
	assign proc_hold = r.cpu.hold;
	assign dram_select = r.cpu.dram_select;
	assign proc_data_lo = r.cpu.data_lo;
	assign eprom_ce_n = r.rom.eprom_ce_n;
	assign eprom_addr = r.rom.eprom_addr;
	assign io_read_strobe_n = r.rom.io_read_strobe_n;

endmodule : brb_ctrl

// ===== brb_ctrl_monitor.sv
// assertion checker for the rom boot controller ports
`timescale 1ns/1ns
module brb_ctrl_monitor (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pslverr,
	// processor bus
	input wire logic [31:3] proc_addr,
	input wire logic [2:0] byte_enable_lines,
	input wire logic proc_ready_n,
	input wire logic cache_enable_input_n,
	input wire logic proc_hold,
	// eprom
	input wire logic eprom_ce_n,
	input wire logic [16:0] eprom_addr,
	input wire logic io_read_strobe_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [5:0] low_cnt;
	////////////////////////////////
	// cycles with chip enable low, saturating so a stuck enable never wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt <= 6'h00;
		end else if (eprom_ce_n) begin
			low_cnt <= 6'h00;
		end else if (low_cnt != 6'h3f) begin
			low_cnt <= low_cnt + 6'h01;
		end
	end
	sequence rd_end;
		$rose(eprom_ce_n);
	endsequence
	sequence float_wait;
		proc_hold[*6] ##1 !proc_hold;
	endsequence
	////////////////////////////////
	wait_states_a: assert property (rd_end |-> low_cnt >= 6'h16)
		else $error("rom read too short");
	ready_at_end_a: assert property (rd_end |-> !proc_ready_n && proc_hold)
		else $error("ready not at read end");
	ready_pulse_a: assert property (!proc_ready_n |=> proc_ready_n)
		else $error("ready longer than one cycle");
	float_hold_a: assert property ($rose(proc_hold) |-> float_wait)
		else $error("hold not six cycles");
	no_overlap_a: assert property (proc_hold |-> eprom_ce_n && io_read_strobe_n)
		else $error("rom driven during recovery");
	oe_strobe_a: assert property (io_read_strobe_n == eprom_ce_n)
		else $error("strobe apart from enable");
	window_decode_a: assert property (!eprom_ce_n |-> &proc_addr[31:25])
		else $error("rom enabled outside window");
	upper_addr_a: assert property (!eprom_ce_n |-> eprom_addr[16:3] == proc_addr[16:3])
		else $error("upper rom address wrong");
	mux_code_a: assert property (!eprom_ce_n && proc_addr[24] |-> eprom_addr[2:0] == byte_enable_lines)
		else $error("mux not on byte enables");
	cache_code_a: assert property (!eprom_ce_n |-> cache_enable_input_n == !proc_addr[24])
		else $error("cache enable wrong");
	unmapped_err_a: assert property (psel && penable && paddr > 12'h008 |-> pslverr)
		else $error("no error on unmapped offset");
endmodule : brb_ctrl_monitor

// ===== brb_decode.sv
// address decode and low-address mux for the eprom window
`timescale 1ns/1ns
`include "brb_cfg.svh"
module brb_decode (
	// request and mapping control
	input wire brb_pkg::brb_req_t req,
	input wire logic boot_map,
	// decode result
	output brb_pkg::brb_dec_t dec
);

	// true when every address bit in [msb:lsb] is one
	function automatic logic all_ones(input logic [31:3] a, input int msb, input int lsb);
		logic r;
		r = 1'b1;
		for (int i = 3; i <= 31; i++) begin
			if (i <= msb && i >= lsb && !a[i]) begin
				r = 1'b0;
			end
		end
		return r;
	endfunction : all_ones

	logic in_win;
	logic in_boot;
	logic use_be;

	// top 32 mbytes belong to the eprom, 16x its 2 mbyte size [R10]
	assign in_win = all_ones(req.addr, `BRB_WIN_MSB, `BRB_WIN_LSB);
	assign in_boot = all_ones(req.addr, `BRB_WIN_MSB, `BRB_BOOT_LSB);

	// with map clear the bootstrap locations go to dram instead [R4] [R5]
	assign dec.eprom_hit = in_win && (boot_map || !in_boot);
	assign dec.dram_hit = in_boot && !boot_map;
	assign dec.code = req.addr[`BRB_CODE_BIT];

	// byte enables drive a2..a0 for code or while booting [R8] [R12]
	// with the select held on the byte enables this acts as the mux-free wiring [R15]
	assign use_be = boot_map || req.addr[`BRB_CODE_BIT];

	// upper 14 bits straight from the processor address [R7]
	// data window steps bytes by 2^21, lanes advance by 8 [R9] [R13]
	assign dec.eprom_addr = {req.addr[`BRB_UPPER_MSB:`BRB_UPPER_LSB],
		use_be ? req.byte_enable_lines : req.addr[`BRB_STEP_MSB:`BRB_STEP_LSB]};

endmodule : brb_decode

// ===== brb_pkg.sv
// types for the byte rom boot interface controller
package brb_pkg;

	// sequencer states
	typedef enum logic [1:0] {
		BRB_IDLE = 2'b00,
		BRB_ACCESS = 2'b01,
		BRB_RECOVER = 2'b10
	} brb_state_t;

	// one processor local bus request as seen at the pins
	typedef struct packed {
		logic ads;
		logic wr;
		logic [31:3] addr;
		logic [2:0] byte_enable_lines;
	} brb_req_t;

	// result of the address decode
	typedef struct packed {
		logic eprom_hit;
		logic dram_hit;
		logic code;
		logic [16:0] eprom_addr;
	} brb_dec_t;

	// eprom side pins
	typedef struct packed {
		logic eprom_ce_n;
		logic [16:0] eprom_addr;
		logic io_read_strobe_n;
	} brb_rom_t;

	// processor side answers
	typedef struct packed {
		logic ready_n;
		logic cache_enable_input_n;
		logic hold;
		logic dram_select;
		logic [7:0] data_lo;
	} brb_cpu_t;

endpackage : brb_pkg

// ===== brb_rom_model.sv
// byte wide eprom model
`timescale 1ns/1ns
module brb_rom_model #(
	parameter int ACC = 0
) (
	// controls and address
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic [16:0] addr,
	// data outputs, one byte per read as in byte-wide boot fetches
	output logic [7:0] data = 8'h00
);
	logic [7:0] last = 8'h00;
	////////////////////////////////
	// released outputs show the inverse of the last byte, never a floating value
	always @(ce_n or oe_n or addr) begin
		if (!ce_n && !oe_n) begin
			last = addr[7:0] ^ addr[15:8];
			data <= #ACC last;
		end else begin
			data <= ~last;
		end
	end
endmodule : brb_rom_model

// ===== brb_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module brb_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pins in, synchronised copy out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} brb_sync_st_t;

	brb_sync_st_t r;
	brb_sync_st_t next_r;

	// the first stage feeds only the second stage
	always_comb begin
		next_r.s1 = d;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q = r.s2;

endmodule : brb_sync

// ===== test_brb_ctrl.sv
// self-checking bench for the rom boot controller
`timescale 1ns/1ns
`include "brb_cfg.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; $display("MISMATCH %0t value differs", $time); end end
module test_brb_ctrl;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic proc_ads_n = 1'b1;
	logic proc_wr = 1'b0;
	logic [31:3] proc_addr = '0;
	logic [2:0] be_lines = 3'h0;
	logic [31:0] prdata;
	logic pready, pslverr, proc_ready_n, cache_n, proc_hold, dram_select, rom_ce_n, rom_oe_n;
	logic [7:0] data_lo, rom_data;
	logic [7:0] rom_last = 8'h00;
	logic [16:0] rom_addr;
	logic [32:0] apb_q[$];
	logic [7:0] proc_q[$];
	logic map = 1'b1;
	logic [15:0] rnd = 16'd12;
	logic [15:0] n_reads = 16'h0;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	always #5 pclk = ~pclk;
	brb_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .proc_ads_n(proc_ads_n), .proc_wr(proc_wr), .proc_addr(proc_addr),
		.byte_enable_lines(be_lines), .proc_ready_n(proc_ready_n),
		.cache_enable_input_n(cache_n), .proc_hold(proc_hold), .dram_select(dram_select),
		.proc_data_lo(data_lo), .eprom_data(rom_data), .eprom_ce_n(rom_ce_n),
		.eprom_addr(rom_addr), .io_read_strobe_n(rom_oe_n));
	// slow rom, inside the access time the controller allows
	brb_rom_model #(.ACC(180)) u_rom (.ce_n(rom_ce_n), .oe_n(rom_oe_n), .addr(rom_addr),
		.data(rom_data));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results
	////////////////////////////////
	// watcher: oldest note is compared whenever an answer shows
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			results();
		end
		if (psel && penable && pready && !pwrite) `CHK({pslverr, prdata}, apb_q.pop_front())
		if (proc_ready_n === 1'b0) `CHK(data_lo, proc_q.pop_front())
	end
	////////////////////////////////
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] exp);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) apb_q.push_back(exp);
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// one processor cycle; the rom byte expected is worked out from the mux rules
	task automatic cpu(input logic w, input logic [31:3] a, input logic [2:0] b);
		logic rom;
		logic [16:0] ea;
		rom = (&a[31:25]) && (map || !(&a[24:21]));
		// while booting the byte enables are the low address bits
		ea = {a[16:3], (map || a[24]) ? b : a[23:21]};
		if (rom && !w) rom_last = ea[7:0] ^ ea[15:8];
		if (rom) proc_q.push_back(rom_last);
		if (rom && !w) n_reads = n_reads + 16'h1;
		@(posedge pclk);
		proc_ads_n <= 1'b0;
		proc_wr <= w;
		proc_addr <= a;
		be_lines <= b;
		@(posedge pclk);
		proc_ads_n <= 1'b1;
		if (rom) while (proc_ready_n !== 1'b0) @(posedge pclk);
		else repeat (6) @(posedge pclk);
		while (proc_hold !== 1'b0) @(posedge pclk);
		@(posedge pclk);
		`CHK(dram_select, !rom && (&a[31:21]))
	endtask : cpu
	////////////////////////////////
	initial begin
		logic [31:3] a;
		logic [2:0] b;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `BRB_CTRL_OFS, 32'h0, 33'h1);
		apb(1'b0, `BRB_STATUS_OFS, 32'h0, 33'h4);
		apb(1'b0, 12'h00c, 32'h0, 33'h100000000);
		for (int i = 0; i < 24; i++) begin
			if (i == 12) begin
				// software has left byte-wide boot mode, so remap the rom away
				map = 1'b0;
				apb(1'b1, `BRB_CTRL_OFS, 32'h20, 33'h0);
			end
			rnd = lfsr(rnd);
			a = {7'h7f, rnd[15:12], rnd[11:0], rnd[5:0]};
			if (i % 4 == 1) a[24:21] = 4'hf;
			if (i % 8 == 7) a[31] = 1'b0;
			b = rnd[3:1];
			// outside boot mode the processor never issues codes 001 or 010
			if (!map && (b == 3'h1 || b == 3'h2)) b = 3'h3;
			cpu(i % 6 == 5, a, b);
		end
		apb(1'b0, `BRB_RDCNT_OFS, 32'h0, {17'h0, n_reads});
		apb(1'b1, `BRB_RDCNT_OFS, 32'h0, 33'h0);
		apb(1'b0, `BRB_RDCNT_OFS, 32'h0, 33'h0);
		apb(1'b0, `BRB_CTRL_OFS, 32'h0, 33'h20);
		apb(1'b0, `BRB_STATUS_OFS, 32'h0, 33'h0);
		results();
	end
endmodule : test_brb_ctrl
bind brb_ctrl brb_ctrl_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .pslverr(pslverr), .proc_addr(proc_addr),
	.byte_enable_lines(byte_enable_lines), .proc_ready_n(proc_ready_n),
	.cache_enable_input_n(cache_enable_input_n), .proc_hold(proc_hold),
	.eprom_ce_n(eprom_ce_n), .eprom_addr(eprom_addr), .io_read_strobe_n(io_read_strobe_n));
